// file: core/pbo_pkg.sv
// Constants for the bridge ordering and address parity block
//==========================================================
// Contract
// (R1) Delayed reads are answered with retry and queued as delayed requests.
// (R2) Delayed read data is buffered and returned toward the initiator bus.
// (R3) Writes are forwarded one by one, never combined, merged or collapsed.
// (R4) Ordering position is fixed only when a transaction ends without retry.
// (R5) Retried transactions may complete in any order among retried ones.
// (R6) Initiators needing order issue one delayed transaction and repeat fairly.
// (R7) Opposite direction writes are unordered; both directions run concurrently.
// (R8) Posted write acceptance never waits on delayed transaction progress.
// (R9) Posted writes complete in the order they were accepted.
// (R10) Delayed read waits until earlier same direction posted writes complete.
// (R11) Read completion waits until earlier same direction posted writes complete.
// (R12) Delayed write never issues ahead of earlier same direction posted writes.
// (R13) Fair arbiter lets posted writes pass delayed requests and completions.
// (R14) Requests never pass requests; completions never pass completions.
// (R15) Software must read back after posted writes; no hardware flush.
// (R16) Address parity is checked on both buses and forwarded unchanged.
// (R17) Address parity is checked for every transaction and command.
// (R18) Primary parity error with response enabled suppresses primary claim.
// (R19) Primary parity error always sets primary detected parity flag.
// (R20) Primary error raises system error only with both enables set.
// (R21) Secondary error with response suppresses claim; flag always set.
// (R22) Secondary error raises system error with enable and bridge response.
// (R23) Memory write and write-and-invalidate are posted writes.
// (R24) I/O and configuration writes are delayed writes, retried first.
//==========================================================
package pbo_pkg;
    // APB register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_QUEUE = 8'h08;
    // Control fields
    localparam int CTRL_PRI_RESP = 0;
    localparam int CTRL_SERR_EN = 1;
    localparam int CTRL_SEC_RESP = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    // Status fields, write one to clear
    localparam int STAT_PRI_DETPAR = 0;
    localparam int STAT_SIG_SERR = 1;
    localparam int STAT_SEC_DETPAR = 2;
    localparam logic [2:0] STAT_RESET = 3'h0;
    // Bus commands
    localparam logic [3:0] CMD_IO_READ = 4'h2;
    localparam logic [3:0] CMD_IO_WRITE = 4'h3;
    localparam logic [3:0] CMD_MEM_READ = 4'h6;
    localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
    localparam logic [3:0] CMD_CFG_READ = 4'ha;
    localparam logic [3:0] CMD_CFG_WRITE = 4'hb;
    localparam logic [3:0] CMD_MEM_READ_MULT = 4'hc;
    localparam logic [3:0] CMD_MEM_READ_LINE = 4'he;
    localparam logic [3:0] CMD_MEM_WRITE_INV = 4'hf;
    // Transaction kinds on the issue port
    localparam logic [2:0] KIND_PW = 3'h0;
    localparam logic [2:0] KIND_DRR = 3'h1;
    localparam logic [2:0] KIND_DWR = 3'h2;
    localparam logic [2:0] KIND_DRC = 3'h3;
    localparam logic [2:0] KIND_DWC = 3'h4;
    // Command classes
    localparam logic [1:0] CLS_POSTED = 2'h0;
    localparam logic [1:0] CLS_DREAD = 2'h1;
    localparam logic [1:0] CLS_DWRITE = 2'h2;
    localparam logic [1:0] CLS_NONE = 2'h3;
    // Posted write queue depth
    localparam int PW_DEPTH = 4;
    localparam logic [2:0] PW_FULL = 3'h4;
endpackage

// file: core/pbo_order_parity.sv
// Ordering engine for both directions plus address parity checking
`timescale 1ns/1ps
module pbo_order_parity (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Transactions taken on the initiator bus, index 0 down, 1 up
    input wire logic [1:0] in_valid,
    input wire logic [1:0][3:0] in_cmd,
    input wire logic [1:0][31:0] in_data,
    output logic [1:0] pw_ready,
    output logic [1:0] dr_ready,
    output logic [1:0] in_retry,
    // Completions returning, index is direction of travel
    input wire logic [1:0] cpl_valid,
    input wire logic [1:0] cpl_read,
    input wire logic [1:0][31:0] cpl_data,
    output logic [1:0] cpl_ready,
    // Issue port toward the far bus
    output logic [1:0] out_valid,
    output logic [1:0][2:0] out_kind,
    output logic [1:0][31:0] out_data,
    input wire logic [1:0] out_done,
    input wire logic [1:0] out_retry,
    // Address phase observation, index 0 primary, 1 secondary
    input wire logic [1:0] addr_valid,
    input wire logic [1:0][31:0] addr_ad,
    input wire logic [1:0][3:0] addr_cbe,
    input wire logic [1:0] addr_par,
    input wire logic [1:0] claim_hit,
    output logic primary_device_select,
    output logic secondary_device_select,
    output logic primary_system_error_out,
    output logic [1:0] fwd_par
);
    import pbo_pkg::*;

    //==========================================================
    // State
    //==========================================================
    typedef struct packed {
        logic [2:0] ctrl;
        logic [2:0] stat;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [1:0][PW_DEPTH-1:0][31:0] pw_mem;
        logic [1:0][1:0] pw_rd;
        logic [1:0][1:0] pw_wr;
        logic [1:0][2:0] pw_cnt;
        logic [1:0][7:0] pw_acc;
        logic [1:0][7:0] pw_done;
        logic [1:0] dr_v;
        logic [1:0] dr_wr;
        logic [1:0][31:0] dr_data;
        logic [1:0][7:0] dr_tag;
        logic [1:0] dc_v;
        logic [1:0] dc_rd;
        logic [1:0][31:0] dc_data;
        logic [1:0][7:0] dc_tag;
        logic [1:0] out_v;
        logic [1:0][2:0] out_kind;
        logic [1:0][31:0] out_data;
        logic [1:0][1:0] out_src;
        logic [1:0] rr_pw;
        logic [1:0] pw_ready;
        logic [1:0] dr_ready;
        logic [1:0] cpl_ready;
        logic [1:0] in_retry;
        logic [1:0] devsel;
        logic serr;
        logic [1:0] fwd_par;
    } pbo_state_type;

    pbo_state_type s_q;
    pbo_state_type s_d;

    // Command class decode, shared by both directions
    function automatic logic [1:0] cmd_class(input logic [3:0] cmd);
        logic [1:0] c;
        c = CLS_NONE;
        unique case (cmd)
            CMD_MEM_WRITE, CMD_MEM_WRITE_INV: c = CLS_POSTED;
            CMD_IO_WRITE, CMD_CFG_WRITE: c = CLS_DWRITE;
            CMD_IO_READ, CMD_MEM_READ, CMD_CFG_READ,
            CMD_MEM_READ_MULT, CMD_MEM_READ_LINE: c = CLS_DREAD;
            default: c = CLS_NONE;
        endcase
        return c;
    endfunction

    // Even parity over address, command and parity bit
    function automatic logic addr_perr(input logic [31:0] ad, input logic [3:0] cbe,
                                       input logic par);
        return ^{ad, cbe, par};
    endfunction

    logic [1:0] ape;
    logic [1:0] resp;
    assign ape[0] = addr_valid[0] & addr_perr(addr_ad[0], addr_cbe[0], addr_par[0]);
    assign ape[1] = addr_valid[1] & addr_perr(addr_ad[1], addr_cbe[1], addr_par[1]);
    assign resp[0] = s_q.ctrl[CTRL_PRI_RESP];
    assign resp[1] = s_q.ctrl[CTRL_SEC_RESP];

    //==========================================================
    // Next state
    //==========================================================
    always_comb begin
        logic apb_acc;
        logic pw_ok;
        logic del_ok;
        logic pick_dr;
        logic pw_push;
        logic pw_pop;
        logic [1:0] cls;
        logic [2:0] set;
        apb_acc = 1'b0;
        pw_ok = 1'b0;
        del_ok = 1'b0;
        pick_dr = 1'b0;
        pw_push = 1'b0;
        pw_pop = 1'b0;
        cls = CLS_NONE;
        set = 3'h0;
        s_d = s_q;
        s_d.in_retry = 2'h0;
        s_d.devsel = 2'h0;
        s_d.serr = 1'b0;

        // APB: answer one cycle into the access phase
        apb_acc = psel & penable;
        s_d.pready = apb_acc & ~s_q.pready;
        if (apb_acc && !s_q.pready) begin
            s_d.pslverr = 1'b0;
            s_d.prdata = 32'h0;
            unique case (paddr)
                ADDR_CTRL: s_d.prdata = {29'h0, s_q.ctrl};
                ADDR_STATUS: s_d.prdata = {29'h0, s_q.stat};
                ADDR_QUEUE: s_d.prdata = {21'h0, s_q.pw_cnt[1], 1'b0, s_q.pw_cnt[0],
                                          s_q.dc_v[1], s_q.dr_v[1], s_q.dc_v[0], s_q.dr_v[0]};
                default: s_d.pslverr = 1'b1;
            endcase
        end

        // Per direction queues; directions never wait on each other
        // (R7) independent directions
        for (int d = 0; d < 2; d++) begin
            pw_push = 1'b0;
            pw_pop = 1'b0;
            cls = cmd_class(in_cmd[d]);
            // (R11) completion tagged with posted writes ahead
            if (cpl_valid[d] && s_q.cpl_ready[d]) begin
                // (R2) read data held for return
                s_d.dc_v[d] = 1'b1;
                s_d.dc_rd[d] = cpl_read[d];
                s_d.dc_data[d] = cpl_data[d];
                s_d.dc_tag[d] = s_q.pw_acc[d];
            end
            if (in_valid[d]) begin
                // (R23) memory writes go to the posted queue
                if (cls == CLS_POSTED && s_q.pw_ready[d]) begin
                    // (R3) one entry per write, never merged
                    s_d.pw_mem[d][s_q.pw_wr[d]] = in_data[d];
                    s_d.pw_wr[d] = s_q.pw_wr[d] + 2'h1;
                    s_d.pw_acc[d] = s_q.pw_acc[d] + 8'h1;
                    pw_push = 1'b1;
                end else if ((cls == CLS_DREAD || cls == CLS_DWRITE) && s_q.dr_ready[d]) begin
                    // (R1) reads retried and queued
                    // (R24) I/O and config writes retried and queued
                    s_d.dr_v[d] = 1'b1;
                    s_d.dr_wr[d] = (cls == CLS_DWRITE);
                    s_d.dr_data[d] = in_data[d];
                    s_d.dr_tag[d] = s_q.pw_acc[d];
                    s_d.in_retry[d] = 1'b1;
                end
            end
            // Issue finished or retried
            if (s_q.out_v[d] && (out_done[d] || out_retry[d])) begin
                s_d.out_v[d] = 1'b0;
                // (R4) position fixed only on non-retry end
                if (out_done[d]) begin
                    unique case (s_q.out_src[d])
                        2'h0: begin
                            pw_pop = 1'b1;
                            s_d.pw_rd[d] = s_q.pw_rd[d] + 2'h1;
                            s_d.pw_done[d] = s_q.pw_done[d] + 8'h1;
                        end
                        2'h1: s_d.dr_v[d] = 1'b0;
                        2'h2: s_d.dc_v[d] = 1'b0;
                        default: s_d.out_v[d] = 1'b0;
                    endcase
                end
            end else if (!s_q.out_v[d]) begin
                pw_ok = (s_q.pw_cnt[d] != 3'h0);
                // (R10) reads wait for earlier posted writes
                // (R12) delayed writes wait too
                pick_dr = s_q.dr_v[d] && (s_q.dr_tag[d] == s_q.pw_done[d]);
                // (R14) requests pass completions, single slot each
                del_ok = pick_dr || (s_q.dc_v[d] && (s_q.dc_tag[d] == s_q.pw_done[d]));
                // (R13) alternate between posted and delayed
                if (pw_ok && (!del_ok || !s_q.rr_pw[d])) begin
                    // (R9) head of the posted queue only
                    s_d.out_v[d] = 1'b1;
                    s_d.out_src[d] = 2'h0;
                    s_d.out_kind[d] = KIND_PW;
                    s_d.out_data[d] = s_q.pw_mem[d][s_q.pw_rd[d]];
                    s_d.rr_pw[d] = 1'b1;
                end else if (del_ok) begin
                    // (R5) retried entries re-arbitrate freely
                    s_d.out_v[d] = 1'b1;
                    s_d.rr_pw[d] = 1'b0;
                    if (pick_dr) begin
                        s_d.out_src[d] = 2'h1;
                        s_d.out_kind[d] = s_q.dr_wr[d] ? KIND_DWR : KIND_DRR;
                        s_d.out_data[d] = s_q.dr_data[d];
                    end else begin
                        s_d.out_src[d] = 2'h2;
                        s_d.out_kind[d] = s_q.dc_rd[d] ? KIND_DRC : KIND_DWC;
                        s_d.out_data[d] = s_q.dc_data[d];
                    end
                end
            end
            s_d.pw_cnt[d] = s_q.pw_cnt[d] + {2'h0, pw_push} - {2'h0, pw_pop};
            // (R8) posted ready depends on posted space alone
            s_d.pw_ready[d] = (s_d.pw_cnt[d] != PW_FULL);
            s_d.dr_ready[d] = ~s_d.dr_v[d];
            s_d.cpl_ready[d] = ~s_d.dc_v[d];
        end

        // Address parity on both buses
        // (R17) every address phase checked
        for (int b = 0; b < 2; b++) begin
            // (R18) claim suppressed on error with response
            // (R21) same on the secondary side
            s_d.devsel[b] = addr_valid[b] & claim_hit[b] & ~(ape[b] & resp[b]);
            // (R22) secondary error gated by bridge response bit
            // (R20) primary error gated by its response bit
            if (ape[b] && s_q.ctrl[CTRL_SERR_EN] && resp[b]) begin
                s_d.serr = 1'b1;
                set[STAT_SIG_SERR] = 1'b1;
            end
        end
        // (R19) detected flags set regardless of response
        set[STAT_PRI_DETPAR] = ape[0];
        set[STAT_SEC_DETPAR] = ape[1];
        // (R16) parity forwarded unchanged to the other bus
        if (addr_valid[1]) begin
            s_d.fwd_par[0] = addr_par[1];
        end
        if (addr_valid[0]) begin
            s_d.fwd_par[1] = addr_par[0];
        end

        // Register writes at the accepting edge; a new event beats the clear
        if (apb_acc && s_q.pready && pwrite) begin
            if (paddr == ADDR_CTRL) begin
                s_d.ctrl = pwdata[2:0];
            end
            if (paddr == ADDR_STATUS) begin
                s_d.stat = s_q.stat & ~pwdata[2:0];
            end
        end
        s_d.stat = s_d.stat | set;
    end

    //==========================================================
    // Registers
    //==========================================================
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.ctrl <= CTRL_RESET;
            s_q.stat <= STAT_RESET;
            s_q.pw_ready <= 2'h3;
            s_q.dr_ready <= 2'h3;
            s_q.cpl_ready <= 2'h3;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flops
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign pw_ready = s_q.pw_ready;
    assign dr_ready = s_q.dr_ready;
    assign in_retry = s_q.in_retry;
    assign cpl_ready = s_q.cpl_ready;
    assign out_valid = s_q.out_v;
    assign out_kind = s_q.out_kind;
    assign out_data = s_q.out_data;
    assign primary_device_select = s_q.devsel[0];
    assign secondary_device_select = s_q.devsel[1];
    assign primary_system_error_out = s_q.serr;
    assign fwd_par = s_q.fwd_par;

    //==========================================================
    // Checks
    //==========================================================
    a_pri_no_claim: assert property (@(posedge clock) disable iff (!rst_n) // R18
        (ape[0] && resp[0]) |=> !primary_device_select)
        else $error("primary claimed despite address parity error");
    a_sec_no_claim: assert property (@(posedge clock) disable iff (!rst_n) // R21
        (ape[1] && resp[1]) |=> !secondary_device_select)
        else $error("secondary claimed despite address parity error");
    a_pri_det_flag: assert property (@(posedge clock) disable iff (!rst_n) // R19
        ape[0] |=> s_q.stat[STAT_PRI_DETPAR])
        else $error("primary detected parity flag not set");
    a_pri_serr_out: assert property (@(posedge clock) disable iff (!rst_n) // R20
        (ape[0] && resp[0] && s_q.ctrl[CTRL_SERR_EN])
        |=> primary_system_error_out && s_q.stat[STAT_SIG_SERR])
        else $error("system error missing after primary parity error");
    a_serr_cause: assert property (@(posedge clock) disable iff (!rst_n) // R22
        primary_system_error_out |-> $past(s_q.ctrl[CTRL_SERR_EN])
        && ($past(ape[0] && resp[0]) || $past(ape[1] && resp[1])))
        else $error("system error without enabled cause");
    a_read_retry: assert property (@(posedge clock) disable iff (!rst_n) // R1
        (in_valid[0] && dr_ready[0] && cmd_class(in_cmd[0]) == CLS_DREAD)
        |=> in_retry[0] && !dr_ready[0])
        else $error("delayed read not retried and queued");
    a_posted_no_retry: assert property (@(posedge clock) disable iff (!rst_n) // R23
        (in_valid[1] && pw_ready[1] && cmd_class(in_cmd[1]) == CLS_POSTED)
        |=> !in_retry[1])
        else $error("posted write was retried");
    a_dr_after_pw: assert property (@(posedge clock) disable iff (!rst_n) // R10
        (out_valid[0] && out_kind[0] == KIND_DRR) |-> s_q.pw_done[0] == s_q.dr_tag[0])
        else $error("delayed read issued ahead of posted write");
    a_cpl_after_pw: assert property (@(posedge clock) disable iff (!rst_n) // R11
        (out_valid[1] && out_kind[1] == KIND_DRC) |-> s_q.pw_done[1] == s_q.dc_tag[1])
        else $error("read completion returned ahead of posted write");
endmodule

// file: tb/pbo_far_model.sv
// Far-bus target model that completes issued transactions and logs them
`timescale 1ns/1ps
module pbo_far_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Issue port of the bridge
    input wire logic [1:0] out_valid,
    input wire logic [1:0][2:0] out_kind,
    input wire logic [1:0][31:0] out_data,
    output logic [1:0] out_done,
    output logic [1:0] out_retry,
    // Knobs set by the bench
    input wire logic [3:0] wait_cycles,
    input wire logic [1:0] retry_once
);
    import pbo_pkg::*;
    logic [2:0] log_kind [2][$];
    logic [31:0] log_data [2][$];
    int cnt [2];
    logic [1:0] retried;
    //==========================================================
    // Target side
    //==========================================================
    // One engine per direction
    // completes without waiting on others
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            out_done <= 2'h0;
            out_retry <= 2'h0;
            retried <= 2'h0;
            cnt <= '{0, 0};
        end else begin
            for (int d = 0; d < 2; d++) begin
                if (out_done[d] || out_retry[d]) begin
                    out_done[d] <= 1'b0;
                    out_retry[d] <= 1'b0;
                    cnt[d] <= 0;
                end else if (out_valid[d] && cnt[d] < int'(wait_cycles)) begin
                    cnt[d] <= cnt[d] + 1;
                end else if (out_valid[d] && retry_once[d] && !retried[d]) begin
                    // First attempt refused once
                    out_retry[d] <= 1'b1;
                    retried[d] <= 1'b1;
                end else if (out_valid[d]) begin
                    out_done[d] <= 1'b1;
                    log_kind[d].push_back(out_kind[d]);
                    log_data[d].push_back(out_data[d]);
                end
            end
        end
    end
endmodule

// file: tb/pbo_order_parity_tb_top.sv
// Self-checking bench for the ordering and address parity block
`timescale 1ns/1ps
module pbo_order_parity_tb_top;
    import pbo_pkg::*;
    logic clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, pri_sel, sec_sel, serr, er;
    logic [1:0] in_valid = 2'h0, cpl_valid = 2'h0, cpl_read = 2'h0, addr_valid = 2'h0;
    logic [1:0] addr_par = 2'h0, claim_hit = 2'h0, retry_once = 2'h0;
    logic [1:0][3:0] in_cmd = 8'h00, addr_cbe = 8'h00;
    logic [1:0][31:0] in_data = 64'h0, cpl_data = 64'h0, addr_ad = 64'h0;
    logic [1:0] pw_ready, dr_ready, in_retry, cpl_ready, out_valid, out_done, out_retry, fwd_par;
    logic [1:0][2:0] out_kind;
    logic [1:0][31:0] out_data;
    logic [3:0] wait_cycles = 4'h0;
    logic [31:0] rd;
    int miscompares = 0;
    int n_compared = 0;
    // 10 MHz clock
    always #50 clock = ~clock;
    //==========================================================
    // Design and far side
    //==========================================================
    pbo_order_parity DUT (
        .clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .in_valid, .in_cmd, .in_data, .pw_ready, .dr_ready, .in_retry, .cpl_valid, .cpl_read,
        .cpl_data, .cpl_ready, .out_valid, .out_kind, .out_data, .out_done, .out_retry,
        .addr_valid, .addr_ad, .addr_cbe, .addr_par, .claim_hit, .fwd_par,
        .primary_device_select(pri_sel), .secondary_device_select(sec_sel),
        .primary_system_error_out(serr));
    pbo_far_model far (
        .clock, .rst_n, .out_valid, .out_kind, .out_data, .out_done, .out_retry, .wait_cycles,
        .retry_once);
    //==========================================================
    // Shared tasks
    //==========================================================
    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic end_sim;
        $display("Compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Spent wait counts as a mismatch
    task automatic hang(input string nm);
        check({nm, "_wait"}, 32'h0, 32'h1);
        end_sim();
    endtask
    // Request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        if (n == 20) hang("apb");
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one posted write, delayed transaction or completion offered at a time
    task automatic offer(input int d, input logic [3:0] c, input logic [31:0] v,
                         input logic cp = 1'b0);
        int n;
        logic pst;
        pst = (c == CMD_MEM_WRITE) || (c == CMD_MEM_WRITE_INV);
        @(posedge clock);
        if (cp) begin
            cpl_valid[d] <= 1'b1;
            cpl_read[d] <= c[0];
            cpl_data[d] <= v;
        end else begin
            in_valid[d] <= 1'b1;
            in_cmd[d] <= c;
            in_data[d] <= v;
        end
        for (n = 0; n < 80; n++) begin
            @(posedge clock);
            if ((cp ? cpl_ready[d] : pst ? pw_ready[d] : dr_ready[d]) === 1'b1) break;
        end
        if (n == 80) hang("offer");
        cpl_valid[d] <= 1'b0;
        in_valid[d] <= 1'b0;
        @(negedge clock);
        if (!cp) check("in_retry", 32'(in_retry[d]), 32'(!pst));
    endtask
    // Next far-side completion in direction d
    task automatic expect_out(input int d, input logic [2:0] k, input logic [31:0] v);
        int n;
        for (n = 0; n < 300 && far.log_kind[d].size() == 0; n++) @(posedge clock);
        if (n == 300) hang("issue");
        check("out_kind", 32'(far.log_kind[d].pop_front()), 32'(k));
        check("out_data", far.log_data[d].pop_front(), v);
    endtask
    //==========================================================
    // Scenarios
    //==========================================================
    task automatic test_reset;
        check("ready", 32'({pw_ready, dr_ready, cpl_ready}), 32'h3f);
        check("outs", 32'({out_valid, in_retry, pri_sel, sec_sel, serr, fwd_par}), 32'h0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check("status", rd, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'hffffffff);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check("ctrl", rd, 32'h7);
        apb(1'b1, 8'h40, 32'h1);
        check("pslverr", 32'(er), 32'h1);
        check("unmapped", rd, 32'h0);
        $display("test_reset done");
    endtask
    // Same word twice still gives two writes
    task automatic test_posted;
        wait_cycles = 4'h5;
        retry_once = 2'h1;
        for (int d = 0; d < 2; d++) begin
            offer(d, CMD_MEM_WRITE, 32'ha0);
            offer(d, CMD_MEM_WRITE_INV, 32'hb0);
            offer(d, CMD_MEM_WRITE, 32'hb0);
            expect_out(d, KIND_PW, 32'ha0);
            expect_out(d, KIND_PW, 32'hb0);
            expect_out(d, KIND_PW, 32'hb0);
        end
        $display("test_posted done");
    endtask
    // each posted write is chased by a transfer on its path
    task automatic test_delayed;
        logic [3:0] cmds [7];
        cmds = '{CMD_IO_READ, CMD_MEM_READ, CMD_CFG_READ, CMD_MEM_READ_MULT,
                 CMD_MEM_READ_LINE, CMD_IO_WRITE, CMD_CFG_WRITE};
        for (int i = 0; i < 7; i++) begin
            offer(i % 2, CMD_MEM_WRITE, 32'hc0 + i);
            offer(i % 2, cmds[i], 32'hd0 + i);
            expect_out(i % 2, KIND_PW, 32'hc0 + i);
            expect_out(i % 2, i > 4 ? KIND_DWR : KIND_DRR, 32'hd0 + i);
        end
        $display("test_delayed done");
    endtask
    task automatic test_completion;
        for (int i = 0; i < 4; i++) begin
            offer(i / 2, CMD_MEM_WRITE, 32'he0 + i);
            offer(i / 2, 4'(i % 2), 32'hf0 + i, 1'b1);
            expect_out(i / 2, KIND_PW, 32'he0 + i);
            expect_out(i / 2, i % 2 ? KIND_DRC : KIND_DWC, 32'hf0 + i);
        end
        $display("test_completion done");
    endtask
    // Posted writes both ways while a read waits
    task automatic test_concurrent;
        logic seen = 1'b0;
        wait_cycles = 4'h8;
        offer(0, CMD_MEM_READ, 32'h11);
        fork
            offer(0, CMD_MEM_WRITE, 32'h12);
            offer(1, CMD_MEM_WRITE, 32'h13);
        join
        check("dr_ready", 32'(dr_ready[0]), 32'h0);
        apb(1'b0, ADDR_QUEUE, 32'h0);
        check("queue", rd, 32'h111);
        for (int n = 0; n < 12; n++) begin
            @(negedge clock);
            seen = seen | (out_valid === 2'h3);
        end
        check("both_dirs", 32'(seen), 32'h1);
        expect_out(0, KIND_DRR, 32'h11);
        expect_out(0, KIND_PW, 32'h12);
        expect_out(1, KIND_PW, 32'h13);
        $display("test_concurrent done");
    endtask
    task automatic test_parity;
        logic b, rp, se, bad, par;
        for (int i = 0; i < 16; i++) begin
            {b, rp, se, bad} = i[3:0];
            apb(1'b1, ADDR_CTRL, b ? {29'h0, rp, se, !rp} : {29'h0, !rp, se, rp});
            apb(1'b1, ADDR_STATUS, 32'h7);
            par = ^{32'h1230 + i, i[3:0]} ^ bad;
            @(posedge clock);
            addr_valid[b] <= 1'b1;
            addr_ad[b] <= 32'h1230 + i;
            addr_cbe[b] <= i[3:0];
            addr_par[b] <= par;
            claim_hit[b] <= 1'b1;
            @(posedge clock);
            addr_valid[b] <= 1'b0;
            @(negedge clock);
            check("pri_sel", 32'(pri_sel), 32'(!b && !(bad && rp)));
            check("sec_sel", 32'(sec_sel), 32'(b && !(bad && rp)));
            check("serr", 32'(serr), 32'(bad && se && rp));
            check("fwd_par", 32'(fwd_par[!b]), 32'(par));
            apb(1'b0, ADDR_STATUS, 32'h0);
            check("status", rd, {29'h0, bad && b, bad && se && rp, bad && !b});
        end
        $display("test_parity done");
    endtask
    //==========================================================
    // Main sequence
    //==========================================================
    initial begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        test_reset();
        test_posted();
        test_delayed();
        test_completion();
        test_concurrent();
        test_parity();
        end_sim();
    end
endmodule
